/* acc_far.sv */
module acc_far
(
  // clock and timer run control
  input  wire logic       clk,
  input  wire logic       tmr_run,
  // analog core controls from the block
  input  wire logic       ana_enable,
  input  wire logic [3:0] pos_route,
  input  wire logic [3:0] neg_route,
  // source and pin levels
  input  wire logic [7:0] vpos [4],
  input  wire logic [7:0] vneg [4],
  // to the block
  output logic            cmp_raw,
  output logic            tmr_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] vp;
  logic [7:0] vn;
  logic [1:0] div    = 2'h0;
  logic [7:0] tmr_ct = 8'h00;
  // unrouted inputs float to ground
  always_comb
  begin
    vp = 8'h00;
    vn = 8'h00;
    for (int i = 0; i < 4; i++)
    begin
      if (pos_route[i]) vp = vpos[i];
      if (neg_route[i]) vn = vneg[i];
    end
  end
  // unpowered core reads low
  assign cmp_raw = ana_enable && (vp > vn);
  // timer clock stands low while stopped
  always_ff @(posedge clk)
  begin
    div <= tmr_run ? div + 2'h1 : 2'h0;
    if (!tmr_run) tmr_clk <= 1'b0;
    else if (div == 2'h2) tmr_clk <= ~tmr_clk;
  end
  // counting on the rising edge keeps clear of the falling-edge latch
  always_ff @(posedge tmr_clk) tmr_ct <= tmr_ct + 8'h01;
endmodule

/* acc_pkg.sv */
// Overview of operation
// - raw result is high when non-inverting input exceeds inverting input
// - reported result is raw result, complemented when output_invert is 1
// - comparator_enable turns comparator on; cleared it draws minimum power
// - result readable as comparator_result and as mirrored_result
// - pin driven by result only with output enable, direction clear, enabled
// - pin_output_enable overrides port latch regardless of comparator_enable
// - internal result re-latched every cycle; pin output passes unlatched
// - speed_power_select resets to 1 normal speed; 0 selects low power
// - hysteresis_enable adds input hysteresis; cleared removes it
// - reported result offered to gate timer as gate source
// - with timer_sync_enable, latch result on gate timer clock falling edge
// - enabled rising or falling result edge sets change_interrupt_flag
// - software clears flag; an edge during the clearing write keeps it set
// - edge detection works while disabled; toggling invert or enable can set flag
// - positive_input_select routes pin, DAC, fixed reference or ground
// - negative_input_select routes one of four analog pins
// - comparator_enable 0 disconnects every input selection
// - result provided to capture/PWM auto-shutdown logic
package acc_pkg;

  // register byte offsets
  localparam logic [7:0] ACC_CTRL_A_OFS = 8'h00;
  localparam logic [7:0] ACC_CTRL_B_OFS = 8'h04;
  localparam logic [7:0] ACC_SHARED_OFS = 8'h08;
  localparam logic [7:0] ACC_FLAG_OFS   = 8'h0c;
  localparam logic [7:0] ACC_PORT_OFS   = 8'h10;

  // comparator_control_a fields
  localparam int CA_EN   = 7;
  localparam int CA_RES  = 6;
  localparam int CA_OE   = 5;
  localparam int CA_INV  = 4;
  localparam int CA_SPD  = 2;
  localparam int CA_HYS  = 1;
  localparam int CA_SYNC = 0;

  // comparator_control_b fields
  localparam int CB_RISE = 7;
  localparam int CB_FALL = 6;
  localparam int CB_PSEL = 4;
  localparam int CB_NSEL = 0;

  // single-bit fields of the other registers
  localparam int SHR_MIR = 0;
  localparam int FLG_CIF = 0;
  localparam int PRT_DIR = 0;
  localparam int PRT_LAT = 1;

  // reset values and writable masks
  localparam logic [7:0] ACC_CTRL_A_RST = 8'h04;
  localparam logic [7:0] ACC_CTRL_B_RST = 8'h00;
  localparam logic [7:0] ACC_PORT_RST   = 8'h01;
  localparam logic [7:0] ACC_CA_WMASK   = 8'hb7;
  localparam logic [7:0] ACC_CB_WMASK   = 8'hf3;
  localparam logic [7:0] ACC_PRT_WMASK  = 8'h03;

  // non-inverting input sources, in select order
  typedef enum logic [1:0] {ACC_POS_PIN, ACC_POS_DAC, ACC_POS_FREF, ACC_POS_GND} acc_pos_t;

  // one-hot route of a two-bit select, all off when not connected
  function automatic logic [3:0] acc_route(input logic [1:0] sel, input logic on);
    logic [3:0] r;
    r = 4'h0;
    r[sel] = on;
    return r;
  endfunction

endpackage

/* acc_sync2.sv */
module acc_sync2
  import acc_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // asynchronous levels in, synchronised levels out
  input  wire logic [1:0] d,
  output logic      [1:0] q
);

  logic [1:0] meta_r;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      meta_r <= 2'h0;
      q      <= 2'h0;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule

/* acc_top.sv */
module acc_top
  import acc_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  // analog core and its controls
  input  wire logic        cmp_raw,
  output logic             ana_enable,
  output logic             ana_speed_normal,
  output logic             ana_hyst_on,
  output logic      [3:0]  pos_route,
  output logic      [3:0]  neg_route,
  // gate timer clock after its prescaler
  input  wire logic        tmr_clk,
  // comparator output pin
  output logic             pin_out,
  output logic             pin_oe_n,
  // result consumers
  output logic             gate_src,
  output logic             shutdown_src,
  output logic             change_flag
);

  logic [7:0]  ctrl_a_r;
  logic [7:0]  ctrl_b_r;
  logic [7:0]  port_r;
  logic        flag_r;
  logic        flag_nxt;
  logic        result_r;
  logic        sync_res_r;
  logic        prev_r;
  logic        tclk_d_r;
  logic        wr_ph_r;
  logic [7:0]  addr_r;
  logic [1:0]  sync_q;
  logic        raw_s;
  logic        tclk_s;
  logic        tclk_fall;
  logic        en;
  logic        oe;
  logic        inv;
  logic        sync_en;
  logic        adj;
  logic        reported;
  logic        rise_pulse;
  logic        fall_pulse;
  logic        edge_ev;
  logic        addr_ok;
  logic        we_a;
  logic        we_b;
  logic        we_flag;
  logic        we_port;
  logic        clr;
  logic [7:0]  wbyte;
  logic [7:0]  rd_byte;

  // both outside levels cross into the clock domain here
  acc_sync2 u_sync
  (
    .clk    (clk),
    .resetn (resetn),
    .d      ({tmr_clk, cmp_raw}),
    .q      (sync_q)
  );

  assign raw_s  = sync_q[0];
  assign tclk_s = sync_q[1];

  // control fields
  assign en      = ctrl_a_r[CA_EN];
  assign oe      = ctrl_a_r[CA_OE];
  assign inv     = ctrl_a_r[CA_INV];
  assign sync_en = ctrl_a_r[CA_SYNC];

  // analog controls
  assign ana_enable       = en;
  assign ana_speed_normal = ctrl_a_r[CA_SPD];
  assign ana_hyst_on      = ctrl_a_r[CA_HYS];
  assign pos_route = acc_route(ctrl_b_r[CB_PSEL +: 2], en);
  assign neg_route = acc_route(ctrl_b_r[CB_NSEL +: 2], en);

  // a stopped comparator reads low, so invert still reaches the edge logic
  assign adj = (en & raw_s) ^ inv;

  // timer clock fall; the timer counts on the rise, so they never race
  assign tclk_fall = tclk_d_r & ~tclk_s;

  // reported result: per-cycle latch or timer-synchronised latch
  assign reported     = sync_en ? sync_res_r : result_r;
  assign gate_src     = reported;
  assign shutdown_src = reported;

  // edge pulses from successive samples
  assign rise_pulse = reported & ~prev_r;
  assign fall_pulse = ~reported & prev_r;
  assign edge_ev = (rise_pulse & ctrl_b_r[CB_RISE]) | (fall_pulse & ctrl_b_r[CB_FALL]);

  // pin path bypasses the cycle latch; enable off leaves the override but stops drive
  assign pin_out  = oe ? adj : port_r[PRT_LAT];
  assign pin_oe_n = port_r[PRT_DIR] | (oe & ~en);

  // bus decode; only the low byte of each word is stored
  assign addr_ok = hsel & hready & htrans[1];
  assign wbyte   = hwdata[7:0];
  assign we_a    = wr_ph_r && (addr_r == ACC_CTRL_A_OFS);
  assign we_b    = wr_ph_r && (addr_r == ACC_CTRL_B_OFS);
  assign we_flag = wr_ph_r && (addr_r == ACC_FLAG_OFS);
  assign we_port = wr_ph_r && (addr_r == ACC_PORT_OFS);
  assign clr     = we_flag & wbyte[FLG_CIF];

  // a new edge outweighs the clearing write
  assign flag_nxt    = edge_ev | (flag_r & ~clr);
  assign change_flag = flag_r;

  // read mux over the registered address; unmapped reads zero
  always_comb
  begin
    rd_byte = 8'h00;
    unique case (addr_r)
      ACC_CTRL_A_OFS: rd_byte = (ctrl_a_r & ACC_CA_WMASK) | (8'(reported) << CA_RES);
      ACC_CTRL_B_OFS: rd_byte = ctrl_b_r;
      ACC_SHARED_OFS: rd_byte = 8'(reported) << SHR_MIR;
      ACC_FLAG_OFS:   rd_byte = 8'(flag_r) << FLG_CIF;
      ACC_PORT_OFS:   rd_byte = port_r;
      default:        rd_byte = 8'h00;
    endcase
  end

  assign hrdata    = {24'h000000, rd_byte};
  assign hreadyout = 1'b1;  // zero wait states
  assign hresp     = 1'b0;  // always okay

  // address phase capture
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_ph_r <= 1'b0;
      addr_r  <= 8'h00;
    end
    else if (hready)
    begin
      wr_ph_r <= addr_ok & hwrite;
      addr_r  <= addr_ok ? haddr[7:0] : addr_r;
    end
  end

  // control registers
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_a_r <= ACC_CTRL_A_RST;
      ctrl_b_r <= ACC_CTRL_B_RST;
      port_r   <= ACC_PORT_RST;
    end
    else
    begin
      if (we_a)
        ctrl_a_r <= wbyte & ACC_CA_WMASK;
      if (we_b)
        ctrl_b_r <= wbyte & ACC_CB_WMASK;
      if (we_port)
        port_r <= wbyte & ACC_PRT_WMASK;
    end
  end

  // result latches, edge history and flag
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      result_r   <= 1'b0;
      sync_res_r <= 1'b0;
      prev_r     <= 1'b0;
      tclk_d_r   <= 1'b0;
      flag_r     <= 1'b0;
    end
    else
    begin
      result_r   <= adj;
      sync_res_r <= tclk_fall ? adj : sync_res_r;
      prev_r     <= reported;
      tclk_d_r   <= tclk_s;
      flag_r     <= flag_nxt;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_no_fall;
    sync_en && !tclk_fall;
  endsequence

  sequence s_inv_up_idle;
    $rose(inv) && !en && $stable(en) && !sync_en;
  endsequence

  sequence s_inv_down_idle;
    $fell(inv) && !en && $stable(en) && !sync_en;
  endsequence

  sequence s_rise_seen;
    rise_pulse && ctrl_b_r[CB_RISE];
  endsequence

  sequence s_fall_seen;
    fall_pulse && ctrl_b_r[CB_FALL];
  endsequence

  AST_POLARITY: assert property
    (!sync_en |=> sync_en || reported == (($past(en) & $past(raw_s)) ^ $past(inv)))
    else $error("reported result does not follow polarity");

  AST_MIRROR: assert property
    (wr_ph_r == 1'b0 && addr_r == ACC_SHARED_OFS |-> hrdata[SHR_MIR] == reported)
    else $error("mirrored result differs from reported result");

  AST_PIN_DRIVE: assert property
    (!pin_oe_n && oe |-> en && !port_r[PRT_DIR])
    else $error("pin driven by result without all conditions");

  AST_PIN_OVERRIDE: assert property
    (oe |-> pin_out == ((en & raw_s) ^ inv))
    else $error("pin not overridden by comparator output");

  AST_ROUTE_OFF: assert property
    (!en |-> pos_route == 4'h0 && neg_route == 4'h0)
    else $error("inputs connected while comparator disabled");

  AST_ROUTE_SEL: assert property
    (en |-> $onehot(pos_route) && pos_route[ctrl_b_r[CB_PSEL +: 2]])
    else $error("positive input route wrong");

  AST_SYNC_HOLD: assert property
    (s_no_fall ##1 s_no_fall |-> $stable(reported))
    else $error("synchronised result moved without timer clock fall");

  AST_FLAG_SET: assert property
    (s_rise_seen |=> flag_r)
    else $error("enabled rising edge did not set flag");

  AST_SET_WINS: assert property
    (edge_ev && clr |=> flag_r)
    else $error("edge lost during clearing write");

  AST_CLEAR: assert property
    (flag_r && clr && !edge_ev |=> !flag_r)
    else $error("flag not cleared by write");

  AST_IDLE_EDGE: assert property
    (s_inv_up_idle |-> ##1 (rise_pulse && !fall_pulse))
    else $error("invert toggle while disabled gave no edge");

  AST_PULSE: assert property
    (rise_pulse |=> !rise_pulse)
    else $error("edge pulse longer than one cycle");

  // edge, flag, latch, polarity, consumer, route and analog control checks beyond the basic set
  AST_FLAG_FALL: assert property
    (s_fall_seen |=> flag_r)
    else $error("enabled falling edge did not set flag");

  AST_NO_SPURIOUS: assert property
    (!flag_r && !edge_ev |=> !flag_r)
    else $error("flag set without an enabled edge");

  AST_FALL_PULSE: assert property
    (fall_pulse |=> !fall_pulse)
    else $error("falling edge pulse longer than one cycle");

  AST_PULSE_EXCL: assert property
    (!(rise_pulse && fall_pulse))
    else $error("rising and falling pulse together");

  AST_FALL_IDLE: assert property
    (s_inv_down_idle |-> ##1 (fall_pulse && !rise_pulse))
    else $error("invert clear while disabled gave no edge");

  AST_DISABLED_LOW: assert property
    (!en |-> adj == inv)
    else $error("stopped comparator not read as low before invert");

  AST_RESULT_REL: assert property
    (!sync_en |-> reported == $past(adj))
    else $error("internal result not re-latched each cycle");

  // the sync latch only moves on a detected timer clock fall
  AST_SYNC_TAKE: assert property
    (sync_en && tclk_fall |=> sync_res_r == $past(adj))
    else $error("synchronised latch missed timer clock fall");

  AST_GATE_SRC: assert property
    (gate_src == reported && shutdown_src == reported)
    else $error("consumers do not see reported result");

  AST_ROUTE_NEG: assert property
    (en |-> $onehot(neg_route) && neg_route[ctrl_b_r[CB_NSEL +: 2]])
    else $error("negative input route wrong");

  AST_ANALOG_CTRL: assert property
    (ana_speed_normal == ctrl_a_r[CA_SPD] && ana_hyst_on == ctrl_a_r[CA_HYS])
    else $error("analog controls differ from register");

  // pin checks; the pin path must not wait for the cycle latch
  AST_PIN_UNLATCHED: assert property
    (oe && en && $stable(ctrl_a_r) && $changed(raw_s) |-> $changed(pin_out))
    else $error("pin output lagged the comparator");

  AST_PIN_LATCH: assert property
    (!oe |-> pin_out == port_r[PRT_LAT])
    else $error("pin lost port latch without override");

  AST_PIN_RELEASE: assert property
    (port_r[PRT_DIR] |-> pin_oe_n)
    else $error("pin driven while direction is input");

  // bus side
  AST_MIRROR_A: assert property
    (wr_ph_r == 1'b0 && addr_r == ACC_CTRL_A_OFS |-> hrdata[CA_RES] == reported)
    else $error("control result bit differs from reported result");

  AST_RO_BITS: assert property
    ((ctrl_a_r & ~ACC_CA_WMASK) == 8'h00 && (ctrl_b_r & ~ACC_CB_WMASK) == 8'h00)
    else $error("read-only or unused control bit stored");

  AST_HRDATA_TOP: assert property
    (hrdata[31:8] == 24'h000000)
    else $error("upper read data not zero");

  AST_BUS_OKAY: assert property
    (hreadyout && !hresp)
    else $error("bus answer not ready and okay");

endmodule

/* tb_analog_comparator_control.sv */
module tb_analog_comparator_control;
  timeunit 1ns;
  timeprecision 1ns;
  import acc_pkg::*;
  logic clk = 0, resetn = 0, hsel = 0, hwrite = 0, tmr_run = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 0;
  logic hreadyout, hresp, cmp_raw, ana_enable, ana_speed_normal, ana_hyst_on;
  logic [3:0] pos_route, neg_route;
  logic tmr_clk, pin_out, pin_oe_n, gate_src, shutdown_src, change_flag;
  logic [7:0] vpos [4] = '{8'h90, 8'h20, 8'h30, 8'h00};
  logic [7:0] vneg [4] = '{8'h40, 8'h50, 8'h60, 8'h70};
  int err_total = 0, check_count = 0;
  acc_top dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .cmp_raw(cmp_raw), .ana_enable(ana_enable),
    .ana_speed_normal(ana_speed_normal), .ana_hyst_on(ana_hyst_on), .pos_route(pos_route),
    .neg_route(neg_route), .tmr_clk(tmr_clk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
    .gate_src(gate_src), .shutdown_src(shutdown_src), .change_flag(change_flag));
  acc_far far (.clk(clk), .tmr_run(tmr_run), .ana_enable(ana_enable), .pos_route(pos_route),
    .neg_route(neg_route), .vpos(vpos), .vneg(vneg), .cmp_raw(cmp_raw), .tmr_clk(tmr_clk));
  // clock
  initial
  begin
    forever #50 clk = ~clk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
      err_total++;
    end
  endtask
  // single word transfer; hready waits are cut short by the watchdog
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'b10;
    haddr  <= {24'h0, a};
    hwrite <= w;
    hsize  <= 3'b010;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h0, d});
    repeat (6) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask
  task automatic t_reset;
    rd(ACC_CTRL_A_OFS, "ctrl_a", 32'h04);
    rd(ACC_CTRL_B_OFS, "ctrl_b", 32'h00);
    rd(ACC_PORT_OFS, "port", 32'h01);
    chk("speed", 1, ana_speed_normal);
    chk("oe_n", 1, pin_oe_n);
    chk("bus_resp", 2'b01, {hresp, hreadyout});
    $display("test reset done");
  endtask
  task automatic t_route;
    wr(ACC_CTRL_A_OFS, 8'h82);
    chk("en", 1, ana_enable);
    chk("speed", 0, ana_speed_normal);
    chk("hyst", 1, ana_hyst_on);
    for (int p = 0; p < 4; p++)
      for (int n = 0; n < 4; n++)
      begin
        wr(ACC_CTRL_B_OFS, 8'(p * 16 + n));
        chk("pos_route", 4'h1 << p, pos_route);
        chk("neg_route", 4'h1 << n, neg_route);
      end
    wr(ACC_CTRL_A_OFS, 8'h00);
    chk("routes_off", 0, {pos_route, neg_route, ana_hyst_on});
    $display("test route done");
  endtask
  task automatic t_polarity;
    for (int i = 0; i < 4; i++)
    begin
      wr(ACC_CTRL_B_OFS, i[1] ? 8'h30 : 8'h00);
      wr(ACC_CTRL_A_OFS, i[0] ? 8'h94 : 8'h84);
      chk("gate_src", !i[1] ^ i[0], gate_src);
      chk("shutdown", !i[1] ^ i[0], shutdown_src);
      rd(ACC_CTRL_A_OFS, "ctrl_a", {i[0] ? 8'h94 : 8'h84} | ((!i[1] ^ i[0]) << CA_RES));
      rd(ACC_SHARED_OFS, "mirror", !i[1] ^ i[0]);
    end
    $display("test polarity done");
  endtask
  task automatic t_pin;
    wr(ACC_CTRL_B_OFS, 8'h00);
    wr(ACC_PORT_OFS, 8'h02);
    chk("latch_pin", 2'b10, {pin_out, pin_oe_n});
    wr(ACC_CTRL_A_OFS, 8'ha4);
    chk("oe_pin", 2'b10, {pin_out, pin_oe_n});
    wr(ACC_CTRL_B_OFS, 8'h30);
    chk("oe_pin0", 2'b00, {pin_out, pin_oe_n});
    wr(ACC_CTRL_A_OFS, 8'h24);
    chk("off_oe_n", 1, pin_oe_n);
    chk("off_override", 0, pin_out);
    wr(ACC_PORT_OFS, 8'h01);
    chk("dir_in", 1, pin_oe_n);
    $display("test pin done");
  endtask
  task automatic t_edge;
    wr(ACC_CTRL_A_OFS, 8'h84);
    wr(ACC_FLAG_OFS, 8'h01);
    wr(ACC_CTRL_B_OFS, 8'hb0);
    chk("no_flag", 0, change_flag);
    wr(ACC_CTRL_B_OFS, 8'h80);
    chk("rise_flag", 1, change_flag);
    wr(ACC_FLAG_OFS, 8'h00);
    chk("keep_flag", 1, change_flag);
    wr(ACC_FLAG_OFS, 8'h01);
    chk("clr_flag", 0, change_flag);
    wr(ACC_CTRL_B_OFS, 8'hb0);
    chk("fall_off", 0, change_flag);
    wr(ACC_CTRL_B_OFS, 8'h40);
    wr(ACC_CTRL_B_OFS, 8'h70);
    chk("fall_flag", 1, change_flag);
    wr(ACC_CTRL_A_OFS, 8'h04);
    wr(ACC_CTRL_B_OFS, 8'h80);
    wr(ACC_FLAG_OFS, 8'h01);
    wr(ACC_CTRL_A_OFS, 8'h14);
    chk("inv_flag", 1, change_flag);
    // back to back: the fall pulse lands in the clearing write's data phase
    wr(ACC_CTRL_B_OFS, 8'hc0);
    bus(1'b1, ACC_CTRL_A_OFS, 32'h04);
    bus(1'b1, ACC_FLAG_OFS, 32'h01);
    repeat (6) @(posedge clk);
    chk("set_wins", 1, change_flag);
    wr(ACC_FLAG_OFS, 8'h01);
    chk("clr_again", 0, change_flag);
    $display("test edge done");
  endtask
  task automatic t_sync;
    wr(ACC_CTRL_B_OFS, 8'h30);
    wr(ACC_CTRL_A_OFS, 8'h84);
    wr(ACC_CTRL_A_OFS, 8'h85);
    wr(ACC_CTRL_B_OFS, 8'h00);
    chk("held", 0, gate_src);
    tmr_run <= 1;
    repeat (12) @(posedge clk);
    tmr_run <= 0;
    repeat (8) @(posedge clk);
    chk("synced", 1, gate_src);
    $display("test sync done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // main sequence
  initial
  begin
    hsel = 1;
    repeat (3) @(posedge clk);
    resetn <= 1;
    @(posedge clk);
    t_reset();
    t_route();
    t_polarity();
    t_pin();
    t_edge();
    t_sync();
    complete_run();
  end
  // run needs about 465 cycles
  initial
  begin
    #1000000;
    err_total++;
    complete_run();
  end
endmodule
